// File: common/plcpr_consts.svh
// offsets, field positions, reset values and timing figures of the
// power-line modem control register block.
// assumes a byte-wide register port and a 250 MHz system clock.
`ifndef PLCPR_CONSTS_SVH
`define PLCPR_CONSTS_SVH

// ======================================================================
// register byte addresses
`define PLCPR_A_GAIN_GLOBAL 16'hfe24
`define PLCPR_A_LAUNCH_B0 16'hfe26
`define PLCPR_A_LAUNCH_B1 16'hfe27
`define PLCPR_A_LAUNCH_B2 16'hfe28
`define PLCPR_A_LAUNCH_B3 16'hfe29
`define PLCPR_A_STATUS_CTRL 16'hfe2a
`define PLCPR_A_PHY_SYSTEM_CONFIG 16'hfe2c
`define PLCPR_A_TIMEBASE_B0 16'hfe47
`define PLCPR_A_TIMEBASE_B1 16'hfe48
`define PLCPR_A_TIMEBASE_B2 16'hfe49
`define PLCPR_A_TIMEBASE_B3 16'hfe4a
`define PLCPR_A_FEATURE_CFG 16'hfe68
`define PLCPR_A_PREAMBLE_GAIN 16'hfe9b
`define PLCPR_A_BODY_GAIN 16'hfe9c

// ======================================================================
// reset values
`define PLCPR_RST_GAIN 8'hff
`define PLCPR_RST_STATUS 8'h87
`define PLCPR_RST_SYS 8'h04
`define PLCPR_RST_FEATURE 8'h1f

// ======================================================================
// field positions
`define PLCPR_SC_IRQ 0
`define PLCPR_SC_TXARM 2
`define PLCPR_SY_RST 0
`define PLCPR_SY_ERR 1
`define PLCPR_SY_WDEN 2
`define PLCPR_SY_LPD 3
`define PLCPR_SY_CPD 4
`define PLCPR_FC_CRC 0
`define PLCPR_FC_DET2 1
`define PLCPR_FC_DET1 2
`define PLCPR_FC_CIPHER 3
`define PLCPR_FC_PAD 4
`define PLCPR_FC_IREF 5
`define PLCPR_FEATURE_MASK 8'h3f
// status bits 7 and 1 read back as their reset level
`define PLCPR_STATUS_FIXED 8'h82

// ======================================================================
// timing
`define PLCPR_CLK_PS 4000
`define PLCPR_TICK_PS 10000000
`define PLCPR_TICK_CYCLES (`PLCPR_TICK_PS / `PLCPR_CLK_PS)
`define PLCPR_WDOG_MS 200
// divide first: the plain product of ms and ps per ms overflows 32 bits
`define PLCPR_WDOG_CYCLES (`PLCPR_WDOG_MS * (1000000000 / `PLCPR_CLK_PS))
`define PLCPR_TB_MAX 20'hfffff

`endif

// File: common/plcpr_pkg.sv
// types shared by the modem control register block.
// assumes the constants header is included where figures are needed.
package plcpr_pkg;
  typedef logic [7:0] plcpr_byte_t;
  typedef logic [19:0] plcpr_time_t;
  typedef logic signed [15:0] plcpr_sample_t;
  // gray path idle -> armed -> active
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ARMED = 2'b01,
    TX_ACTIVE = 2'b11
  } plcpr_txst_e;
endpackage

// File: src/plcpr_phy_control_regs.sv
// control and status registers of the power-line modem physical layer:
// time base, scheduled launch, interrupt flag, soft reset, power-down,
// watchdog, feature enables and transmit gain scaling.
// assumes a synchronous byte register port and datapath inputs on clk_sys.
`include "plcpr_consts.svh"
module plcpr_phy_control_regs #(
  parameter int unsigned TICK_CYCLES = `PLCPR_TICK_CYCLES,
  parameter int unsigned WDOG_CYCLES = `PLCPR_WDOG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [15:0] regAddr,
  input wire plcpr_pkg::plcpr_byte_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output plcpr_pkg::plcpr_byte_t regRdata,
  input wire logic phyEvent,
  input wire logic phyFault,
  input wire logic txDone,
  input wire plcpr_pkg::plcpr_sample_t sampleIn,
  input wire logic sampleValid,
  input wire logic samplePreamble,
  output plcpr_pkg::plcpr_sample_t sampleOut,
  output logic sampleOutValid,
  output logic txStart,
  output logic host_irq_n,
  output logic layerReset,
  output logic layer_powerdown,
  output logic converter_powerdown,
  output logic interference_ref_mode,
  output logic padding_count_after_code,
  output logic cipherEnable,
  output logic early_detect1_enable,
  output logic early_detect2_enable,
  output logic hw_crc_enable
);
  import plcpr_pkg::*;

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // refuse figures the counters cannot serve
  if (TICK_CYCLES < 1 || WDOG_CYCLES < 2)
  begin : g_badPeriod
    $error("tick or watchdog period too short");
  end

  logic [TW-1:0] tickCnt_q;
  logic tick;
  plcpr_time_t timeBase_q;
  plcpr_time_t tbSnap_q;
  plcpr_time_t launchShadow_q;
  plcpr_time_t launch_q;
  plcpr_txst_e txState_q;
  logic irqFlag_q;
  logic [7:0] sysCfg_q;
  logic wdErr_q;
  logic [31:0] wdCnt_q;
  logic [7:0] feature_q;
  plcpr_byte_t gainGlobal_q;
  plcpr_byte_t gainPre_q;
  plcpr_byte_t gainBody_q;
  plcpr_sample_t stage1_q;
  logic stage1Valid_q;
  logic wrStatus;
  logic wrSys;
  logic softRst;
  logic wdSample;
  logic launchHit;
  logic irqSet;
  plcpr_byte_t readMux;
  plcpr_byte_t segGain;
  logic signed [24:0] prodSeg;
  logic signed [24:0] prodGlobal;

  assign wrStatus = regWr && regAddr == `PLCPR_A_STATUS_CTRL;
  assign wrSys = regWr && regAddr == `PLCPR_A_PHY_SYSTEM_CONFIG;
  assign softRst = sysCfg_q[`PLCPR_SY_RST];

  // ======================================================================
  // time base
  // prescaler turns the system clock into one 10 us step
  assign tick = tickCnt_q == TW'(TICK_CYCLES - 1);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tickCnt_q <= '0;
    else if (clkEn)
      tickCnt_q <= tick ? '0 : tickCnt_q + TW'(1);
  end

  // free running, the soft reset does not stop it so time stays coherent
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      timeBase_q <= '0;
    else if (clkEn && tick)
      timeBase_q <= timeBase_q + 20'h1; // wraps past the top
  end

  // reading the top byte freezes the rest, so a byte-wise read cannot tear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tbSnap_q <= '0;
    else if (clkEn && regRd && regAddr == `PLCPR_A_TIMEBASE_B0)
      tbSnap_q <= timeBase_q;
  end

  // ======================================================================
  // launch time
  // upper bytes wait in a shadow; the last byte commits the whole value
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      launchShadow_q <= '0;
      launch_q <= '0;
    end
    else if (clkEn && regWr)
    begin
      case (regAddr)
        `PLCPR_A_LAUNCH_B0: launchShadow_q[19:12] <= regWdata;
        `PLCPR_A_LAUNCH_B1: launchShadow_q[11:4] <= regWdata;
        `PLCPR_A_LAUNCH_B2:
        begin
          launchShadow_q[3:0] <= regWdata[7:4];
          launch_q <= {launchShadow_q[19:4], regWdata[7:4]};
        end
        default: launch_q <= launch_q;
      endcase
    end
  end

  // ======================================================================
  // transmit scheduling
  assign launchHit = timeBase_q == launch_q;

  // host write of zero arms, write of one withdraws; soft reset cancels
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txState_q <= TX_IDLE;
      txStart <= 1'b0;
    end
    else if (clkEn)
    begin
      txStart <= 1'b0;
      case (txState_q)
        TX_IDLE:
          if (wrStatus && !regWdata[`PLCPR_SC_TXARM] && !softRst)
            txState_q <= TX_ARMED;
        TX_ARMED:
          if (softRst || (wrStatus && regWdata[`PLCPR_SC_TXARM]))
            txState_q <= TX_IDLE;
          else if (launchHit)
          begin
            txState_q <= TX_ACTIVE;
            txStart <= 1'b1;
          end
        TX_ACTIVE:
          if (softRst || txDone)
            txState_q <= TX_IDLE;
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  // ======================================================================
  // interrupt flag, low while an interrupt is pending
  // a new event in the clearing cycle wins, so no event is lost
  assign irqSet = phyEvent || wdSample && phyFault && !wdErr_q;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irqFlag_q <= 1'b1;
    else if (clkEn)
    begin
      if (irqSet)
        irqFlag_q <= 1'b0;
      else if (wrStatus && regWdata[`PLCPR_SC_IRQ])
        irqFlag_q <= 1'b1;
    end
  end

  // pin is a flop fed with the flag's next value, so it matches the flag in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      host_irq_n <= 1'b1;
    else if (clkEn)
      host_irq_n <= irqSet ? 1'b0 :
        (wrStatus && regWdata[`PLCPR_SC_IRQ]) ? 1'b1 : irqFlag_q;
  end

  // ======================================================================
  // system configuration; the error bit is not host writable
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sysCfg_q <= `PLCPR_RST_SYS; // watchdog on by default
    else if (clkEn && wrSys)
      sysCfg_q <= {3'h0, regWdata[4:2], 1'b0, regWdata[0]};
  end

  // ======================================================================
  // watchdog, sampled once per period while enabled and out of reset
  assign wdSample = wdCnt_q == WDOG_CYCLES - 1;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wdCnt_q <= '0;
    else if (clkEn)
    begin
      if (!sysCfg_q[`PLCPR_SY_WDEN] || softRst || wdSample)
        wdCnt_q <= '0;
      else
        wdCnt_q <= wdCnt_q + 32'h1;
    end
  end

  // only the soft reset clears the error, which forces the recovery path
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wdErr_q <= 1'b0;
    else if (clkEn)
    begin
      if (softRst)
        wdErr_q <= 1'b0;
      else if (wdSample && phyFault)
        wdErr_q <= 1'b1;
    end
  end

  // ======================================================================
  // control outputs, all registered
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      layerReset <= 1'b0;
      layer_powerdown <= 1'b0;
      converter_powerdown <= 1'b0;
    end
    else if (clkEn)
    begin
      layerReset <= wrSys ? regWdata[`PLCPR_SY_RST] : softRst;
      layer_powerdown <= wrSys ? regWdata[`PLCPR_SY_LPD] :
        sysCfg_q[`PLCPR_SY_LPD];
      converter_powerdown <= wrSys ? regWdata[`PLCPR_SY_CPD] :
        sysCfg_q[`PLCPR_SY_CPD];
    end
  end

  // ======================================================================
  // feature enables and gains
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      feature_q <= `PLCPR_RST_FEATURE;
    else if (clkEn && regWr && regAddr == `PLCPR_A_FEATURE_CFG)
      feature_q <= regWdata & `PLCPR_FEATURE_MASK;
  end

  // each enable follows its bit directly: one turns the mode on
  assign interference_ref_mode = feature_q[`PLCPR_FC_IREF];
  assign padding_count_after_code = feature_q[`PLCPR_FC_PAD];
  assign cipherEnable = feature_q[`PLCPR_FC_CIPHER];
  assign early_detect1_enable = feature_q[`PLCPR_FC_DET1];
  assign early_detect2_enable = feature_q[`PLCPR_FC_DET2];
  assign hw_crc_enable = feature_q[`PLCPR_FC_CRC];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gainGlobal_q <= `PLCPR_RST_GAIN;
      gainPre_q <= `PLCPR_RST_GAIN;
      gainBody_q <= `PLCPR_RST_GAIN;
    end
    else if (clkEn && regWr)
    begin
      if (regAddr == `PLCPR_A_GAIN_GLOBAL)
        gainGlobal_q <= regWdata;
      if (regAddr == `PLCPR_A_PREAMBLE_GAIN)
        gainPre_q <= regWdata;
      if (regAddr == `PLCPR_A_BODY_GAIN)
        gainBody_q <= regWdata;
    end
  end

  // ======================================================================
  // amplitude scaling: section gain then global gain, product bits 23 to 8 kept.
  // two cuts cost a little resolution but keep each multiplier 16x8
  assign segGain = samplePreamble ? gainPre_q : gainBody_q;
  assign prodSeg = $signed(sampleIn) * $signed({1'b0, segGain});
  assign prodGlobal = $signed(stage1_q) * $signed({1'b0, gainGlobal_q});

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= '0;
      stage1Valid_q <= 1'b0;
      sampleOut <= '0;
      sampleOutValid <= 1'b0;
    end
    else if (clkEn)
    begin
      stage1Valid_q <= sampleValid;
      if (sampleValid)
        stage1_q <= prodSeg[23:8];
      sampleOutValid <= stage1Valid_q;
      if (stage1Valid_q)
        sampleOut <= prodGlobal[23:8];
    end
  end

  // ======================================================================
  // register read; data stands only in the cycle after the strobe
  always_comb
  begin
    readMux = 8'h00;
    case (regAddr)
      `PLCPR_A_GAIN_GLOBAL: readMux = gainGlobal_q;
      `PLCPR_A_LAUNCH_B0: readMux = launchShadow_q[19:12];
      `PLCPR_A_LAUNCH_B1: readMux = launchShadow_q[11:4];
      `PLCPR_A_LAUNCH_B2: readMux = {launchShadow_q[3:0], 4'h0};
      `PLCPR_A_STATUS_CTRL:
        readMux = `PLCPR_STATUS_FIXED |
          {5'h0, txState_q != TX_ACTIVE, 1'b0, irqFlag_q};
      `PLCPR_A_PHY_SYSTEM_CONFIG: readMux = sysCfg_q | {6'h0, wdErr_q, 1'b0};
      `PLCPR_A_TIMEBASE_B0: readMux = timeBase_q[19:12];
      `PLCPR_A_TIMEBASE_B1: readMux = tbSnap_q[11:4];
      `PLCPR_A_TIMEBASE_B2: readMux = {tbSnap_q[3:0], 4'h0};
      `PLCPR_A_FEATURE_CFG: readMux = feature_q;
      `PLCPR_A_PREAMBLE_GAIN: readMux = gainPre_q;
      `PLCPR_A_BODY_GAIN: readMux = gainBody_q;
      default: readMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (clkEn)
      regRdata <= regRd ? readMux : 8'h00;
  end

  // ======================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_armedHit;
    clkEn && txState_q == TX_ARMED && launchHit && !softRst &&
      !(wrStatus && regWdata[`PLCPR_SC_TXARM]);
  endsequence

  a_tb_step: assert property (
    clkEn && tick |=> timeBase_q == $past(timeBase_q) + 20'h1)
    else $error("time base did not step on tick");
  a_tb_hold: assert property (
    clkEn && !tick |=> $stable(timeBase_q))
    else $error("time base moved without tick");
  a_launch_go: assert property (
    s_armedHit |=> txStart && txState_q == TX_ACTIVE)
    else $error("armed launch did not start");
  a_launch_early: assert property (
    txStart && !$past(txStart) |-> $past(launchHit && txState_q == TX_ARMED))
    else $error("start without time match");
  a_irq_pin: assert property (
    clkEn |=> host_irq_n == irqFlag_q)
    else $error("interrupt pin differs from flag");
  a_irq_set: assert property (
    clkEn && phyEvent |=> !irqFlag_q)
    else $error("event did not raise the flag");
  a_wd_error: assert property (
    clkEn && wdSample && phyFault && !softRst |=>
      wdErr_q && (!irqFlag_q || $past(wdErr_q)))
    else $error("watchdog error not flagged");
  a_wd_off: assert property (
    clkEn && !sysCfg_q[`PLCPR_SY_WDEN] |=> wdCnt_q == 32'h0)
    else $error("disabled watchdog sampled");
  a_soft_rst: assert property (
    clkEn && softRst |=> !wdErr_q && (layerReset || $past(wrSys)))
    else $error("layer not held in reset");
  a_commit_only: assert property (
    clkEn && regWr && regAddr != `PLCPR_A_LAUNCH_B2 |=> $stable(launch_q))
    else $error("launch changed without last byte");
  a_gain_path: assert property (
    clkEn && sampleValid ##1 clkEn |=> sampleOutValid)
    else $error("scaled sample missing");
endmodule

// File: verif/plcpr_host_model.sv
// host software model: byte register accesses and the programming
// sequences that software must follow for launch, reset and power-down.
// assumes every task is entered right after a rising edge of clk_sys.
`include "plcpr_consts.svh"
module plcpr_host_model (
  input wire logic clk_sys,
  output logic [15:0] regAddr,
  output plcpr_pkg::plcpr_byte_t regWdata,
  output logic regWr,
  output logic regRd,
  input wire plcpr_pkg::plcpr_byte_t regRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import plcpr_pkg::*;

  // ====================================================================
  // bus cycles
  // idle bus at time zero
  initial
  begin
    regAddr = 16'h0000;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // one-cycle write, then a gap cycle so strobes never toggle twice
  task automatic busWrite(input logic [15:0] a, input plcpr_byte_t d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regWdata <= ~d; // stale data would hide a late capture
    regAddr <= ~a;
    @(posedge clk_sys);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic busRead(input logic [15:0] a, output plcpr_byte_t d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdata;
    @(posedge clk_sys);
  endtask

  // ====================================================================
  // programming sequences
  // all three bytes, most significant first
  task automatic setLaunch(input plcpr_time_t t);
    busWrite(`PLCPR_A_LAUNCH_B0, t[19:12]);
    busWrite(`PLCPR_A_LAUNCH_B1, t[11:4]);
    busWrite(`PLCPR_A_LAUNCH_B2, {t[3:0], 4'h0});
  endtask

  // arm with bit 2 low, keeping the interrupt flag clear
  task automatic arm;
    busWrite(`PLCPR_A_STATUS_CTRL, 8'h01);
  endtask

  task automatic enterReset;
    busWrite(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h05);
  endtask

  task automatic leaveReset;
    busWrite(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h04);
  endtask

  task automatic powerDown;
    busWrite(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h05);
    busWrite(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h1d);
  endtask

  task automatic powerUp;
    busWrite(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h05);
    busWrite(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h04);
  endtask
endmodule

// File: verif/plcpr_phy_control_regs_tb_top.sv
// self-checking bench of the modem control register block.
// assumes short tick and watchdog counts (4 and 16 cycles) and clkEn high except for 40 cycles in the time base test.
`include "plcpr_consts.svh"
module plcpr_phy_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import plcpr_pkg::*;

  // ====================================================================
  // signals and instances
  logic clk_sys, rst_n, clkEn, regWr, regRd, phyEvent, phyFault, txDone;
  logic sampleValid, samplePreamble, sampleOutValid, txStart, host_irq_n;
  logic layerReset, layer_powerdown, converter_powerdown;
  logic interference_ref_mode, padding_count_after_code, cipherEnable;
  logic early_detect1_enable, early_detect2_enable, hw_crc_enable;
  logic [15:0] regAddr;
  logic [7:0] featureVec;
  plcpr_byte_t regWdata, regRdata;
  plcpr_sample_t sampleIn, sampleOut;
  int badCount, checkCount;

  assign featureVec = {2'b00, interference_ref_mode, padding_count_after_code,
    cipherEnable, early_detect1_enable, early_detect2_enable, hw_crc_enable};

  plcpr_phy_control_regs #(.TICK_CYCLES(4), .WDOG_CYCLES(16))
    plcpr_phy_control_regs_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .phyEvent(phyEvent),
    .phyFault(phyFault), .txDone(txDone), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .samplePreamble(samplePreamble),
    .sampleOut(sampleOut), .sampleOutValid(sampleOutValid),
    .txStart(txStart), .host_irq_n(host_irq_n), .layerReset(layerReset),
    .layer_powerdown(layer_powerdown),
    .converter_powerdown(converter_powerdown),
    .interference_ref_mode(interference_ref_mode),
    .padding_count_after_code(padding_count_after_code),
    .cipherEnable(cipherEnable), .early_detect1_enable(early_detect1_enable),
    .early_detect2_enable(early_detect2_enable),
    .hw_crc_enable(hw_crc_enable));

  plcpr_host_model plcpr_host_model_i (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  // ====================================================================
  // helpers
  task automatic chkByte(string n, plcpr_byte_t e, plcpr_byte_t g);
    checkCount++;
    if (g !== e)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkSample(string n, plcpr_sample_t e, plcpr_sample_t g);
    checkCount++;
    if (g !== e)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input plcpr_byte_t d);
    plcpr_host_model_i.busWrite(a, d);
  endtask

  task automatic rd(input logic [15:0] a, output plcpr_byte_t d);
    plcpr_host_model_i.busRead(a, d);
  endtask

  // first byte read snapshots the time base
  task automatic readTime(output plcpr_time_t t);
    plcpr_byte_t b0, b1, b2, b3;
    rd(`PLCPR_A_TIMEBASE_B0, b0);
    rd(`PLCPR_A_TIMEBASE_B1, b1);
    rd(`PLCPR_A_TIMEBASE_B2, b2);
    rd(`PLCPR_A_TIMEBASE_B3, b3);
    chkByte("time_b3", 8'h00, b3);
    chkByte("time_b2_low", 8'h00, {4'h0, b2[3:0]});
    t = {b0, b1, b2[7:4]};
  endtask

  // two truncating stages: segment gain, then global gain
  function automatic plcpr_sample_t expSample(plcpr_sample_t s,
    plcpr_byte_t seg, plcpr_byte_t g);
    int a;
    int b;
    a = (int'(s) * int'(seg)) >>> 8;
    b = (int'(signed'(a[15:0])) * int'(g)) >>> 8;
    return b[15:0];
  endfunction

  // ====================================================================
  // scenarios
  task automatic tReset;
    logic [15:0] ad [11] = '{`PLCPR_A_GAIN_GLOBAL, `PLCPR_A_LAUNCH_B0,
      `PLCPR_A_LAUNCH_B1, `PLCPR_A_LAUNCH_B2, `PLCPR_A_LAUNCH_B3,
      `PLCPR_A_STATUS_CTRL, `PLCPR_A_PHY_SYSTEM_CONFIG, `PLCPR_A_FEATURE_CFG,
      `PLCPR_A_PREAMBLE_GAIN, `PLCPR_A_BODY_GAIN, 16'hfe25};
    plcpr_byte_t ex [11] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h87,
      8'h04, 8'h1f, 8'hff, 8'hff, 8'h00};
    plcpr_byte_t d;
    chkByte("irq_n_reset", 8'h01, {7'h00, host_irq_n});
    for (int i = 0; i < 11; i++)
    begin
      rd(ad[i], d);
      chkByte("reset_value", ex[i], d);
    end
  endtask

  task automatic tFeature;
    plcpr_byte_t d;
    for (int i = 0; i < 6; i++)
    begin
      wr(`PLCPR_A_FEATURE_CFG, 8'h01 << i);
      chkByte("feature_out", 8'h01 << i, featureVec);
    end
    wr(`PLCPR_A_FEATURE_CFG, 8'hff);
    rd(`PLCPR_A_FEATURE_CFG, d);
    chkByte("feature_rd", 8'h3f, d);
    wr(`PLCPR_A_FEATURE_CFG, 8'h1f);
  endtask

  // snapshots 48 cycles apart span exactly 12 ticks
  task automatic tTimeBase;
    plcpr_time_t t0, t1, dt;
    readTime(t0);
    repeat (40) @(posedge clk_sys);
    readTime(t1);
    dt = t1 - t0;
    chkByte("time_step", 8'h0c, dt[7:0]);
    // a low enable freezes the prescaler: 8 enabled cycles give 2 ticks
    clkEn <= 1'b0;
    repeat (40) @(posedge clk_sys);
    clkEn <= 1'b1;
    readTime(t0);
    dt = t0 - t1;
    chkByte("time_frozen", 8'h02, dt[7:0]);
  endtask

  task automatic tLaunch;
    plcpr_time_t t, l, s, dt;
    plcpr_byte_t d;
    int n;
    readTime(t);
    l = t + 20'd40;
    plcpr_host_model_i.setLaunch(l);
    rd(`PLCPR_A_LAUNCH_B0, d);
    chkByte("launch_b0", l[19:12], d);
    rd(`PLCPR_A_LAUNCH_B2, d);
    chkByte("launch_b2", {l[3:0], 4'h0}, d);
    rd(`PLCPR_A_LAUNCH_B3, d);
    chkByte("launch_b3", 8'h00, d);
    plcpr_host_model_i.arm();
    // uncommitted upper byte must not move the launch
    wr(`PLCPR_A_LAUNCH_B0, l[19:12] + 8'h01);
    for (n = 0; n < 400 && txStart !== 1'b1; n++) @(posedge clk_sys);
    readTime(s);
    dt = s - l;
    chkByte("start_gap", 8'h01, {7'h00, dt <= 20'd1});
    rd(`PLCPR_A_STATUS_CTRL, d);
    chkByte("status_tx", 8'h83, d);
    txDone <= 1'b1;
    @(posedge clk_sys);
    txDone <= 1'b0;
    @(posedge clk_sys);
    rd(`PLCPR_A_STATUS_CTRL, d);
    chkByte("status_idle", 8'h87, d);
  endtask

  task automatic tIrq;
    plcpr_byte_t d;
    int n;
    phyEvent <= 1'b1;
    @(posedge clk_sys);
    phyEvent <= 1'b0;
    for (n = 0; n < 4 && host_irq_n !== 1'b0; n++) @(posedge clk_sys);
    chkByte("irq_n_low", 8'h00, {7'h00, host_irq_n});
    rd(`PLCPR_A_STATUS_CTRL, d);
    chkByte("irq_flag", 8'h86, d);
    wr(`PLCPR_A_STATUS_CTRL, 8'h05);
    @(posedge clk_sys);
    chkByte("irq_n_high", 8'h01, {7'h00, host_irq_n});
  endtask

  task automatic tWatchdog;
    plcpr_byte_t d;
    int n;
    phyFault <= 1'b1;
    for (n = 0; n < 40 && host_irq_n !== 1'b0; n++) @(posedge clk_sys);
    chkByte("wd_irq", 8'h00, {7'h00, host_irq_n});
    phyFault <= 1'b0;
    rd(`PLCPR_A_PHY_SYSTEM_CONFIG, d);
    chkByte("wd_error", 8'h06, d);
    plcpr_host_model_i.enterReset();
    @(posedge clk_sys);
    chkByte("layer_rst_on", 8'h01, {7'h00, layerReset});
    rd(`PLCPR_A_PHY_SYSTEM_CONFIG, d);
    chkByte("wd_cleared", 8'h05, d);
    plcpr_host_model_i.leaveReset();
    @(posedge clk_sys);
    chkByte("layer_rst_off", 8'h00, {7'h00, layerReset});
    wr(`PLCPR_A_STATUS_CTRL, 8'h05);
    // a disabled watchdog must ignore a standing fault
    wr(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h00);
    phyFault <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chkByte("wd_off", 8'h01, {7'h00, host_irq_n});
    phyFault <= 1'b0;
    wr(`PLCPR_A_PHY_SYSTEM_CONFIG, 8'h04);
  endtask

  task automatic tPowerDown;
    plcpr_host_model_i.powerDown();
    @(posedge clk_sys);
    chkByte("pd_on", 8'h07, {5'h00, layerReset, layer_powerdown,
      converter_powerdown});
    plcpr_host_model_i.powerUp();
    @(posedge clk_sys);
    chkByte("pd_off", 8'h00, {5'h00, layerReset, layer_powerdown,
      converter_powerdown});
  endtask

  task automatic tGain;
    plcpr_sample_t sv [4] = '{16'h7fff, 16'hc123, 16'h4000, 16'h8000};
    logic pr [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    plcpr_byte_t gg [4] = '{8'hff, 8'hc0, 8'h80, 8'hff};
    plcpr_byte_t pg [4] = '{8'hff, 8'h11, 8'h00, 8'h40};
    plcpr_byte_t bg [4] = '{8'h00, 8'h9a, 8'hff, 8'hff};
    for (int i = 0; i < 4; i++)
    begin
      wr(`PLCPR_A_GAIN_GLOBAL, gg[i]);
      wr(`PLCPR_A_PREAMBLE_GAIN, pg[i]);
      wr(`PLCPR_A_BODY_GAIN, bg[i]);
      sampleIn <= sv[i];
      samplePreamble <= pr[i];
      sampleValid <= 1'b1;
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      @(posedge clk_sys);
      #1;
      chkByte("out_valid", 8'h01, {7'h00, sampleOutValid});
      chkSample("sample_out", expSample(sv[i], pr[i] ? pg[i] : bg[i],
        gg[i]), sampleOut);
      @(posedge clk_sys);
    end
  endtask

  // ====================================================================
  // clock, sequence, watchdog and verdict
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic endOfTest;
    if (badCount == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    phyEvent = 1'b0;
    phyFault = 1'b0;
    txDone = 1'b0;
    sampleIn = 16'h0000;
    sampleValid = 1'b0;
    samplePreamble = 1'b0;
    badCount = 0;
    checkCount = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    tReset();
    tFeature();
    tTimeBase();
    tLaunch();
    tIrq();
    tWatchdog();
    tPowerDown();
    tGain();
    endOfTest();
  end

  // the whole sequence needs well under 2000 cycles; ten times that is a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    endOfTest();
  end
endmodule
